// >>> design/omc_map.svh
// Overview of operation
// - Any reset starts in real-address mode
// - Protection enable selects real or protected
// - Virtual select picks protected or legacy-virtual
// - Legacy virtual only from protected operation
// - Virtual switches on task switch or return; here on task switch (XTASK) only
// - Long active flag bit 10 shows extended
// - Extended entry: protected, paging, long enable
// - Code long bit picks 64-bit or compat
// - Extended feature register governs extended mode
// - Active-low management pin raises management entry
// - Management entry from any operating mode
// - Save context, switch to management space
// - Resume restores exactly the interrupted mode
// - Table pointers hold 64-bit base when extended; here 32-bit bases in every mode
// - Flags and control regs widen to 64; here they stay 32 bits in every mode
// - Priority control reg accessible only extended
// - Debug regs 64-bit in 64-bit sub-mode; here 32 bits, read as 16 in real mode
// - Model-specific regs need privilege level 0
// - Extended mode ignores virtual select sets
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH
`define OMC_A_CR0      12'h000
`define OMC_A_FLAGS    12'h004
`define OMC_A_EFER     12'h008
`define OMC_A_CTL      12'h00C
`define OMC_A_PRIO     12'h010
`define OMC_A_STATUS   12'h014
`define OMC_A_GTP      12'h018
`define OMC_A_VTP      12'h01C
`define OMC_A_LTP      12'h020
`define OMC_A_TSL      12'h024
`define OMC_A_DBG      12'h028
`define OMC_A_SAVED    12'h02C
`define OMC_B_PE       0
`define OMC_B_PG       31
`define OMC_B_VM       17
`define OMC_B_LME      8
`define OMC_B_LMA      10
`define OMC_B_CSL      0
`define OMC_B_CPL      2:1
`define OMC_B_XTASK    3
`define OMC_B_RSM      4
`define OMC_PRIO_W     4
`endif

// >>> design/omc_pkg.sv
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_REAL, OMC_PROT, OMC_V86, OMC_COMPAT, OMC_LONG64, OMC_SMM
  } omc_mode_e;
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } omc_req_s;
endpackage

// >>> design/omc_core.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "omc_map.svh"
module omc_core
  import omc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        sys_mgmt_irq_pin_n_i,
  output logic      [2:0]  mode_o,
  output logic             mgmt_space_o
);
  omc_req_s    req_q;
  logic [31:0] control_reg_zero_q;
  logic [31:0] status_flags_reg_q;
  logic [31:0] ext_feature_ctl_reg_q;
  logic [31:0] ctl_q;
  logic [`OMC_PRIO_W-1:0] task_priority_value_q;
  logic [31:0] ptr_q [4];
  logic [31:0] dbg_q;
  omc_mode_e   mode_q;
  omc_mode_e   saved_mode_q;
  omc_mode_e   next_mode;
  logic        pin_s1_q;
  logic        pin_s2_q;
  logic        pin_s3_q;
  logic        smi_pend_q;
  logic [31:0] rdata;
  logic        wr;
  logic        resume;
  logic        ext_mode;
  logic        priv0;

  assign wr       = req_q.sel && req_q.write;
  assign ext_mode = ext_feature_ctl_reg_q[`OMC_B_LMA];
  assign priv0    = (ctl_q[`OMC_B_CPL] == 2'h0);
  // Resume only meaningful while in management mode
  assign resume   = wr && (req_q.addr == `OMC_A_CTL)
                    && hwdata_i[`OMC_B_RSM] && (mode_q == OMC_SMM);

  // Address phase capture; data phase always zero wait
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_q <= '0;
    end else if (hready_i) begin
      req_q.sel   <= hsel_i && htrans_i[1];
      req_q.write <= hwrite_i;
      req_q.addr  <= {haddr_i[11:2], 2'h0};
    end
  end

  // Pin synchroniser; third stage for the falling edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= sys_mgmt_irq_pin_n_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Edge is latched so a request in management mode waits
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smi_pend_q <= 1'b0;
    end else if (pin_s3_q && !pin_s2_q) begin
      smi_pend_q <= 1'b1;
    end else if (mode_q != OMC_SMM && smi_pend_q) begin
      smi_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      control_reg_zero_q <= 32'h0;
    end else if (wr && req_q.addr == `OMC_A_CR0) begin
      control_reg_zero_q <= hwdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_flags_reg_q <= 32'h0;
    end else if (wr && req_q.addr == `OMC_A_FLAGS) begin
      status_flags_reg_q <= hwdata_i;
      // Virtual select cannot be set outside plain protected
      if (ext_mode || !control_reg_zero_q[`OMC_B_PE]) begin
        status_flags_reg_q[`OMC_B_VM] <= 1'b0;
      end
    end
  end

  // Extended feature register; writes need privilege 0
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_feature_ctl_reg_q <= 32'h0;
    end else begin
      if (wr && req_q.addr == `OMC_A_EFER && priv0) begin
        ext_feature_ctl_reg_q[`OMC_B_LME] <= hwdata_i[`OMC_B_LME];
      end
      if (next_mode == OMC_COMPAT || next_mode == OMC_LONG64) begin
        ext_feature_ctl_reg_q[`OMC_B_LMA] <= 1'b1;
      end else if (next_mode != OMC_SMM) begin
        ext_feature_ctl_reg_q[`OMC_B_LMA] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_q <= 32'h0;
    end else if (wr && req_q.addr == `OMC_A_CTL) begin
      ctl_q <= {27'h0, 1'b0, hwdata_i[3:0]};
    end else begin
      ctl_q[`OMC_B_XTASK] <= 1'b0;
    end
  end

  // Priority register exists only in extended mode
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      task_priority_value_q <= '0;
    end else if (wr && req_q.addr == `OMC_A_PRIO && ext_mode) begin
      task_priority_value_q <= hwdata_i[`OMC_PRIO_W-1:0];
    end
  end

  // Low words of table pointers; high words read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ptr
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ptr_q[gi] <= 32'h0;
        end else if (wr && req_q.addr == (`OMC_A_GTP + 12'(4 * gi))) begin
          ptr_q[gi] <= hwdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_q <= 32'h0;
    end else if (wr && req_q.addr == `OMC_A_DBG) begin
      dbg_q <= hwdata_i;
    end
  end

  // Mode sequencing
  always_comb begin
    next_mode = mode_q;
    case (mode_q)
      OMC_SMM: begin
        if (resume) begin
          next_mode = saved_mode_q;
        end
      end
      OMC_REAL: begin
        if (control_reg_zero_q[`OMC_B_PE]) begin
          next_mode = OMC_PROT;
        end
      end
      OMC_PROT, OMC_V86: begin
        if (!control_reg_zero_q[`OMC_B_PE]) begin
          next_mode = OMC_REAL;
        end else if (control_reg_zero_q[`OMC_B_PG]
                     && ext_feature_ctl_reg_q[`OMC_B_LME]
                     && mode_q == OMC_PROT) begin
          next_mode = ctl_q[`OMC_B_CSL] ? OMC_LONG64 : OMC_COMPAT;
        end else if (ctl_q[`OMC_B_XTASK]) begin
          next_mode = status_flags_reg_q[`OMC_B_VM]
                      ? OMC_V86 : OMC_PROT;
        end
      end
      default: begin
        if (!control_reg_zero_q[`OMC_B_PG]
            || !control_reg_zero_q[`OMC_B_PE]) begin
          next_mode = control_reg_zero_q[`OMC_B_PE] ? OMC_PROT : OMC_REAL;
        end else begin
          next_mode = ctl_q[`OMC_B_CSL] ? OMC_LONG64 : OMC_COMPAT;
        end
      end
    endcase
    if (smi_pend_q && mode_q != OMC_SMM) begin
      next_mode = OMC_SMM;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q       <= OMC_REAL;
      saved_mode_q <= OMC_REAL;
    end else begin
      mode_q <= next_mode;
      if (next_mode == OMC_SMM && mode_q != OMC_SMM) begin
        saved_mode_q <= mode_q;
      end
    end
  end

  // Status tracks next_mode so it lands with the commit
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_o       <= 3'h0;
      mgmt_space_o <= 1'b0;
    end else begin
      mode_o       <= next_mode;
      mgmt_space_o <= (next_mode == OMC_SMM);
    end
  end

  always_comb begin
    rdata = 32'h0;
    if (req_q.addr == `OMC_A_CR0) begin
      rdata = control_reg_zero_q;
    end else if (req_q.addr == `OMC_A_FLAGS) begin
      rdata = status_flags_reg_q;
    end else if (req_q.addr == `OMC_A_EFER && priv0) begin
      rdata = ext_feature_ctl_reg_q;
    end else if (req_q.addr == `OMC_A_CTL) begin
      rdata = ctl_q;
    end else if (req_q.addr == `OMC_A_PRIO && ext_mode) begin
      rdata = {28'h0, task_priority_value_q};
    end else if (req_q.addr == `OMC_A_STATUS) begin
      rdata = {28'h0, mgmt_space_o, mode_o};
    end else if (req_q.addr >= `OMC_A_GTP && req_q.addr <= `OMC_A_TSL) begin
      rdata = ptr_q[req_q.addr[3:2] - 2'h2];
    end else if (req_q.addr == `OMC_A_DBG) begin
      rdata = (mode_q == OMC_REAL) ? {16'h0, dbg_q[15:0]} : dbg_q;
    end else if (req_q.addr == `OMC_A_SAVED) begin
      rdata = {29'h0, saved_mode_q};
    end
  end

  assign hrdata_o    = rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
endmodule

// >>> tb/omc_checker.sv
`timescale 1ns/1ps
module omc_checker
  import omc_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       arst_n_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       sys_mgmt_irq_pin_n_i,
  input wire logic [2:0] mode_o,
  input wire logic       mgmt_space_o
);
  logic [2:0] ent_q;
  // Mode last seen outside management
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ent_q <= 3'h0;
    end else if (mode_o != OMC_SMM) begin
      ent_q <= mode_o;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  reset_real_a: assert property ($rose(arst_n_i) |-> mode_o == OMC_REAL)
    else $error("mode not real after reset");
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus wait or error seen");
  virt_from_prot_a: assert property (
    mode_o == OMC_V86 && $past(mode_o) != OMC_V86 |->
    $past(mode_o) inside {OMC_PROT, OMC_SMM})
    else $error("legacy virtual entered from wrong mode");
  ext_from_prot_a: assert property (
    mode_o inside {OMC_COMPAT, OMC_LONG64} &&
    !($past(mode_o) inside {OMC_COMPAT, OMC_LONG64}) |->
    $past(mode_o) inside {OMC_PROT, OMC_SMM})
    else $error("extended entered from wrong mode");
  ext_no_virt_a: assert property (
    mode_o inside {OMC_COMPAT, OMC_LONG64} |=> mode_o != OMC_V86)
    else $error("legacy virtual entered from extended");
  mgmt_entry_a: assert property (
    $fell(sys_mgmt_irq_pin_n_i) && mode_o != OMC_SMM |->
    ##[1:10] mode_o == OMC_SMM)
    else $error("management entry missing");
  mgmt_space_a: assert property (mgmt_space_o == (mode_o == OMC_SMM))
    else $error("management space flag wrong");
  resume_mode_a: assert property (
    $past(mode_o) == OMC_SMM && mode_o != OMC_SMM |-> mode_o == ent_q)
    else $error("resume went to wrong mode");
  cover property (mode_o == OMC_V86);
  cover property (mode_o == OMC_LONG64);
  cover property (mode_o == OMC_SMM);
endmodule
bind omc_core omc_checker u_chk (
  .sys_clk_i           (sys_clk_i),
  .arst_n_i            (arst_n_i),
  .hreadyout_o         (hreadyout_o),
  .hresp_o             (hresp_o),
  .sys_mgmt_irq_pin_n_i(sys_mgmt_irq_pin_n_i),
  .mode_o              (mode_o),
  .mgmt_space_o        (mgmt_space_o)
);

// >>> tb/omc_pin_model.sv
`timescale 1ns/1ps
module omc_pin_model (
  input  wire logic clk_i,
  input  wire logic fire_i,
  output logic      pin_n_o
);
  logic [3:0] cnt_q = 4'h0;
  // Low for several cycles so a synchroniser cannot miss it
  always @(posedge clk_i) begin
    if (fire_i) cnt_q <= 4'h8;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign pin_n_o = (cnt_q == 4'h0);
endmodule

// >>> tb/cpu_operating_mode_control_tb_top.sv
`timescale 1ns/1ps
`include "omc_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module cpu_operating_mode_control_tb_top;
  import omc_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [2:0]  m;
  } omc_row_s;
  logic        sys_clk_i = 0;
  logic        arst_n_i = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        fire = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hready, hresp, pin_n, mspace;
  wire  [2:0]  mode;
  int          error_cnt = 0;
  int          checked = 0;
  omc_row_s rows [13] = '{
    '{`OMC_A_CR0, 32'h1, OMC_PROT}, '{`OMC_A_FLAGS, 32'h20000, OMC_PROT},
    '{`OMC_A_CTL, 32'h8, OMC_V86}, '{`OMC_A_FLAGS, 32'h0, OMC_V86},
    '{`OMC_A_CTL, 32'h8, OMC_PROT}, '{`OMC_A_EFER, 32'h100, OMC_PROT},
    '{`OMC_A_CR0, 32'h80000001, OMC_COMPAT},
    '{`OMC_A_CTL, 32'h1, OMC_LONG64},
    '{`OMC_A_FLAGS, 32'h20000, OMC_LONG64},
    '{`OMC_A_CTL, 32'h9, OMC_LONG64}, '{`OMC_A_CR0, 32'h0, OMC_REAL},
    '{`OMC_A_FLAGS, 32'h20000, OMC_REAL}, '{`OMC_A_CTL, 32'h8, OMC_REAL}};
  always #2.5 sys_clk_i = ~sys_clk_i;
  omc_core DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .sys_mgmt_irq_pin_n_i(pin_n),
    .mode_o(mode), .mgmt_space_o(mspace));
  omc_pin_model u_pin (.clk_i(sys_clk_i), .fire_i(fire), .pin_n_o(pin_n));
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    // Read before the edge's own updates land: data phase value
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Write, let the mode commit, then check pins and status word
  task automatic step(input logic [11:0] a, input logic [31:0] d,
                      input logic [2:0] m);
    xfer(1'b1, a, d, rd);
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK(mode, m)
    @(posedge sys_clk_i);
    xfer(1'b0, `OMC_A_STATUS, 32'h0, rd);
    `CHK(rd[2:0], m)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      step(rows[i].a, rows[i].d, rows[i].m);
    end
    // Privilege 3 must not touch the feature register
    step(`OMC_A_CTL, 32'h6, OMC_REAL);
    step(`OMC_A_EFER, 32'h0, OMC_REAL);
    xfer(1'b0, `OMC_A_EFER, 32'h0, rd);
    `CHK(rd, 32'h0)
    step(`OMC_A_CTL, 32'h1, OMC_REAL);
    xfer(1'b0, `OMC_A_EFER, 32'h0, rd);
    `CHK(rd, 32'h100)
    step(`OMC_A_CR0, 32'h1, OMC_PROT);
    step(`OMC_A_CR0, 32'h80000001, OMC_LONG64);
    xfer(1'b0, `OMC_A_EFER, 32'h0, rd);
    `CHK(rd, 32'h500)
    xfer(1'b1, `OMC_A_PRIO, 32'hA, rd);
    xfer(1'b0, `OMC_A_PRIO, 32'h0, rd);
    `CHK(rd, 32'hA)
    xfer(1'b1, `OMC_A_LTP, 32'h12345678, rd);
    xfer(1'b0, `OMC_A_LTP, 32'h0, rd);
    `CHK(rd, 32'h12345678)
    xfer(1'b1, `OMC_A_DBG, 32'hABCD1234, rd);
    xfer(1'b0, `OMC_A_DBG, 32'h0, rd);
    `CHK(rd, 32'hABCD1234)
    fire <= 1'b1;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    for (int i = 0; i < 20 && mode !== OMC_SMM; i++) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK(mode, OMC_SMM)
    `CHK(mspace, 1'b1)
    @(posedge sys_clk_i);
    step(`OMC_A_CTL, 32'h11, OMC_LONG64);
    `CHK(mspace, 1'b0)
    // Leaving extended hides the priority register again
    step(`OMC_A_CR0, 32'h1, OMC_PROT);
    xfer(1'b0, `OMC_A_PRIO, 32'h0, rd);
    `CHK(rd, 32'h0)
    xfer(1'b0, 12'h100, 32'h0, rd);
    `CHK(rd, 32'h0)
    arst_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    `CHK(mode, OMC_REAL)
    arst_n_i <= 1'b1;
    step(`OMC_A_CTL, 32'h0, OMC_REAL);
    xfer(1'b0, `OMC_A_EFER, 32'h0, rd);
    `CHK(rd, 32'h0)
    tally_and_finish();
  end
endmodule
